// ---- design/txs_shadow_regs.sv ----
// file: transmit shadow register bank behind an avalon-mm slave
// Notes on behaviour
// - upper halves reserved; read as zero here
// - previous descriptor pointer low half stored
// - previous descriptor pointer high half stored
// - previous byte count copy, twelve bits
// - previous descriptor status half copy
// - next buffer pointer low half stored
// - shadow field access and style writes only while stopped or suspended
// - shadow fields untouched by any reset
// - style 00h narrow structures, ring non-burst
// - style 02h wide structures, ring non-burst
// - style 03h wide structures, bursts allowed
// - style code resets to 00h
// - wide flag read only, derived
//
// Local design decisions: register access over Avalon-MM and the address map.
`timescale 1ns/10ps
module txs_shadow_regs
  import txs_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // avalon-mm slave
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // dma-side capture of the finished descriptor
  input  wire logic        dma_capture,
  input  wire logic [31:0] dma_desc_addr,
  input  wire logic [31:0] dma_desc_word1,
  input  wire logic        dma_next_valid,
  input  wire logic [15:0] dma_next_buf_low,
  // shadow state to the transmit engine
  output logic [15:0]      prev_desc_ptr_low,
  output logic [15:0]      prev_desc_ptr_high,
  output logic [11:0]      prev_byte_count,
  output logic [15:0]      prev_status_copy,
  output logic [15:0]      next_buffer_ptr_low,
  output logic [7:0]       structure_style_code,
  output logic             wide_structure_flag,
  output logic             init_burst_ok,
  output logic             ring_burst_ok,
  output logic             style_valid,
  output logic             stop_bit,
  output logic             suspend_bit
);

  // --------------------------------------------------------------
  // bus handshake
  // --------------------------------------------------------------
  // one wait cycle: a read is taken on the edge after it appears, a write on the edge after that
  logic ack_q;
  logic req;
  logic [31:0] rdata_q;

  assign req             = avs_read | avs_write;
  assign avs_waitrequest = req & ~ack_q;
  assign avs_readdata    = rdata_q;

  // ack pulses for one cycle, then clears so back-to-back works
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end

  // a read raised together with a write is dropped; the write goes ahead
  logic wr_take;
  logic rd_take;
  assign wr_take = avs_write & ack_q;
  assign rd_take = avs_read & ~avs_write & ~ack_q;

  // --------------------------------------------------------------
  // address decode
  // --------------------------------------------------------------
  // one select per register; unmapped offsets select nothing
  logic sel_pdl;
  logic sel_pdh;
  logic sel_pbc;
  logic sel_pst;
  logic sel_nbl;
  logic sel_style;
  logic sel_ctrl;

  always_comb begin
    sel_pdl   = 1'b0;
    sel_pdh   = 1'b0;
    sel_pbc   = 1'b0;
    sel_pst   = 1'b0;
    sel_nbl   = 1'b0;
    sel_style = 1'b0;
    sel_ctrl  = 1'b0;
    if (avs_address == TXS_ADDR_PREV_DESC_LOW) begin
      sel_pdl = 1'b1;
    end else if (avs_address == TXS_ADDR_PREV_DESC_HIGH) begin
      sel_pdh = 1'b1;
    end else if (avs_address == TXS_ADDR_PREV_BCOUNT) begin
      sel_pbc = 1'b1;
    end else if (avs_address == TXS_ADDR_PREV_STATUS) begin
      sel_pst = 1'b1;
    end else if (avs_address == TXS_ADDR_NEXT_BUF_LOW) begin
      sel_nbl = 1'b1;
    end else if (avs_address == TXS_ADDR_STYLE) begin
      sel_style = 1'b1;
    end else if (avs_address == TXS_ADDR_CTRL) begin
      sel_ctrl = 1'b1;
    end
  end

  // --------------------------------------------------------------
  // control: stop and suspend bits
  // --------------------------------------------------------------
  logic stop_q;
  logic suspend_bit_q;
  logic access_ok;

  // stop is set by reset so software can program after power-up
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      stop_q <= 1'b1;
      suspend_bit_q <= 1'b0;
    end else if (wr_take && sel_ctrl && avs_byteenable[0]) begin
      stop_q <= avs_writedata[TXS_STOP_BIT];
      suspend_bit_q <= avs_writedata[TXS_SUSPEND_BIT_BIT];
    end
  end

  assign access_ok   = stop_q | suspend_bit_q;
  assign stop_bit    = stop_q;
  assign suspend_bit = suspend_bit_q;

  // --------------------------------------------------------------
  // style code
  // --------------------------------------------------------------
  logic [TXS_STYLE_W-1:0] style_q;

  // only the code is writable; the wide flag bit is dropped
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      style_q <= TXS_STYLE_RESET;
    end else if (wr_take && access_ok && sel_style && avs_byteenable[0]) begin
      style_q <= avs_writedata[TXS_STYLE_W-1:0];
    end
  end

  assign structure_style_code = style_q;

  txs_style_decode u_style (
    .style_code          (style_q),
    .wide_structure_flag (wide_structure_flag),
    .init_burst_ok       (init_burst_ok),
    .ring_burst_ok       (ring_burst_ok),
    .style_valid         (style_valid)
  );

  // --------------------------------------------------------------
  // shadow fields
  // --------------------------------------------------------------
  // no reset term: contents survive every reset and stop
  logic [15:0] pdl_q;
  logic [15:0] pdh_q;
  logic [11:0] pbc_q;
  logic [15:0] pst_q;
  logic [15:0] nbl_q;
  logic        sw_wr;
  logic [15:0] wmask;
  logic [15:0] wr_half;
  logic [15:0] pbc_wide;
  logic [15:0] pbc_merge;
  logic        we_pdl;
  logic        we_pdh;
  logic        we_pbc;
  logic        we_pst;
  logic        we_nbl;

  assign sw_wr   = wr_take & access_ok;
  assign wr_half = avs_writedata[TXS_HALF_W-1:0];

  // byte lane mask, one lane per enable; lanes 2 and 3 have no field behind them
  for (genvar g = 0; g < TXS_LANES; g++) begin : g_lane
    assign wmask[g*TXS_LANE_W +: TXS_LANE_W] = {TXS_LANE_W{avs_byteenable[g]}};
  end

  // per-register write strobes, live only while stopped or suspended
  assign we_pdl = sw_wr & sel_pdl;
  assign we_pdh = sw_wr & sel_pdh;
  assign we_pbc = sw_wr & sel_pbc;
  assign we_pst = sw_wr & sel_pst;
  assign we_nbl = sw_wr & sel_nbl;

  // unselected lanes keep their old bits, so one-byte writes are safe
  function automatic logic [15:0] lane_merge(
    input logic [15:0] old_v,
    input logic [15:0] new_v,
    input logic [15:0] mask
  );
    return (old_v & ~mask) | (new_v & mask);
  endfunction : lane_merge

  // byte count widened to the lane layout, then cut back to its own width
  assign pbc_wide  = {{(TXS_HALF_W-TXS_BCOUNT_W){1'b0}}, pbc_q};
  assign pbc_merge = lane_merge(pbc_wide, wr_half, wmask);

  // software write wins over a dma capture in the same cycle
  always_ff @(posedge ref_clk) begin
    if (we_pdl) begin
      pdl_q <= lane_merge(pdl_q, wr_half, wmask);
    end else if (dma_capture) begin
      pdl_q <= dma_desc_addr[TXS_HALF_W-1:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (we_pdh) begin
      pdh_q <= lane_merge(pdh_q, wr_half, wmask);
    end else if (dma_capture) begin
      pdh_q <= dma_desc_addr[2*TXS_HALF_W-1:TXS_HALF_W];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (we_pbc) begin
      pbc_q <= pbc_merge[TXS_BCOUNT_W-1:0];
    end else if (dma_capture) begin
      pbc_q <= dma_desc_word1[TXS_BCOUNT_W-1:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (we_pst) begin
      pst_q <= lane_merge(pst_q, wr_half, wmask);
    end else if (dma_capture) begin
      pst_q <= dma_desc_word1[2*TXS_HALF_W-1:TXS_HALF_W];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (we_nbl) begin
      nbl_q <= lane_merge(nbl_q, wr_half, wmask);
    end else if (dma_next_valid) begin
      nbl_q <= dma_next_buf_low;
    end
  end

  assign prev_desc_ptr_low   = pdl_q;
  assign prev_desc_ptr_high  = pdh_q;
  assign prev_byte_count     = pbc_q;
  assign prev_status_copy    = pst_q;
  assign next_buffer_ptr_low = nbl_q;

  // --------------------------------------------------------------
  // read path
  // --------------------------------------------------------------
  // gated reads return zero; upper half always zero
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = TXS_RD_ZERO;
    if (sel_ctrl) begin
      rd_mux[TXS_STOP_BIT] = stop_q;
      rd_mux[TXS_SUSPEND_BIT_BIT] = suspend_bit_q;
    end else if (sel_style) begin
      rd_mux[TXS_STYLE_W-1:0] = style_q;
      rd_mux[TXS_WIDE_BIT]    = wide_structure_flag;
    end else if (!access_ok) begin
      rd_mux = TXS_RD_ZERO;
    end else if (sel_pdl) begin
      rd_mux[TXS_HALF_W-1:0] = pdl_q;
    end else if (sel_pdh) begin
      rd_mux[TXS_HALF_W-1:0] = pdh_q;
    end else if (sel_pbc) begin
      rd_mux[TXS_BCOUNT_W-1:0] = pbc_q;
    end else if (sel_pst) begin
      rd_mux[TXS_HALF_W-1:0] = pst_q;
    end else if (sel_nbl) begin
      rd_mux[TXS_HALF_W-1:0] = nbl_q;
    end
  end

  // read data registered on the taking edge, valid at the ack edge
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= TXS_RD_ZERO;
    end else if (rd_take) begin
      rdata_q <= rd_mux;
    end
  end

endmodule : txs_shadow_regs

// ---- design/txs_pkg.sv ----
// package: register map, field layout and constants of the tx shadow bank
package txs_pkg;
  // register byte addresses (word aligned)
  localparam logic [7:0] TXS_ADDR_PREV_DESC_LOW  = 8'h00;
  localparam logic [7:0] TXS_ADDR_PREV_DESC_HIGH = 8'h04;
  localparam logic [7:0] TXS_ADDR_PREV_BCOUNT    = 8'h08;
  localparam logic [7:0] TXS_ADDR_PREV_STATUS    = 8'h0C;
  localparam logic [7:0] TXS_ADDR_NEXT_BUF_LOW   = 8'h10;
  localparam logic [7:0] TXS_ADDR_STYLE          = 8'h14;
  localparam logic [7:0] TXS_ADDR_CTRL           = 8'h18;

  // field layout
  localparam int TXS_HALF_W   = 16;
  localparam int TXS_BCOUNT_W = 12;
  localparam int TXS_STYLE_W  = 8;
  localparam int TXS_WIDE_BIT = 8;
  localparam int TXS_STOP_BIT = 0;
  localparam int TXS_SUSPEND_BIT_BIT = 1;
  localparam int TXS_LANE_W   = 8;
  localparam int TXS_LANES    = 2;

  // style codes
  localparam logic [7:0] TXS_STYLE_NARROW    = 8'h00;
  localparam logic [7:0] TXS_STYLE_RSVD1     = 8'h01;
  localparam logic [7:0] TXS_STYLE_WIDE_NB   = 8'h02;
  localparam logic [7:0] TXS_STYLE_WIDE_BRST = 8'h03;
  localparam logic [7:0] TXS_STYLE_RESET     = 8'h00;

  // unmapped and reserved read value
  localparam logic [31:0] TXS_RD_ZERO = 32'h0000_0000;
endpackage : txs_pkg

// ---- design/txs_style_decode.sv ----
// file: style code decode into structure width and burst permissions
`timescale 1ns/10ps
module txs_style_decode
  import txs_pkg::*;
(
  input  wire logic [TXS_STYLE_W-1:0] style_code,
  output logic                        wide_structure_flag,
  output logic                        init_burst_ok,
  output logic                        ring_burst_ok,
  output logic                        style_valid
);
  // reserved codes flag invalid and allow no bursts; of those only 01h reports wide
  always_comb begin
    wide_structure_flag = 1'b0;
    init_burst_ok       = 1'b0;
    ring_burst_ok       = 1'b0;
    style_valid         = 1'b0;
    case (style_code)
      TXS_STYLE_NARROW: begin
        init_burst_ok = 1'b1;
        style_valid   = 1'b1;
      end
      TXS_STYLE_RSVD1: begin
        wide_structure_flag = 1'b1;
      end
      TXS_STYLE_WIDE_NB: begin
        wide_structure_flag = 1'b1;
        init_burst_ok       = 1'b1;
        style_valid         = 1'b1;
      end
      TXS_STYLE_WIDE_BRST: begin
        wide_structure_flag = 1'b1;
        init_burst_ok       = 1'b1;
        ring_burst_ok       = 1'b1;
        style_valid         = 1'b1;
      end
      default: begin
        style_valid = 1'b0;
      end
    endcase
  end
endmodule : txs_style_decode

// ---- tb/txs_shadow_regs_properties.sv ----
// checker: port-level properties of the tx shadow register bank
`timescale 1ns/10ps
module txs_shadow_properties
  import txs_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic [7:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        dma_capture,
  input wire logic [31:0] dma_desc_word1,
  input wire logic [15:0] prev_desc_ptr_low,
  input wire logic [11:0] prev_byte_count,
  input wire logic [15:0] prev_status_copy,
  input wire logic [7:0]  structure_style_code,
  input wire logic        wide_structure_flag,
  input wire logic        init_burst_ok,
  input wire logic        ring_burst_ok,
  input wire logic        stop_bit,
  input wire logic        suspend_bit
);
  // ----------------------------------------
  // sequences and properties
  // ----------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence s_wr_done;
    avs_write && !avs_waitrequest;
  endsequence
  sequence s_open;
    stop_bit || suspend_bit;
  endsequence
  a_wait_one_cycle: assert property ($rose(avs_read || avs_write) |->
    avs_waitrequest ##1 !avs_waitrequest) else $error("request not answered after one wait");
  a_gated_write_drop: assert property (s_wr_done ##0 !(stop_bit || suspend_bit)
    ##0 !dma_capture |=> $stable(prev_desc_ptr_low) && $stable(structure_style_code))
    else $error("closed write changed a field");
  a_write_low_half: assert property (s_wr_done ##0 s_open
    ##0 avs_address == TXS_ADDR_PREV_DESC_LOW |=> prev_desc_ptr_low == $past(avs_writedata[15:0]))
    else $error("open write not stored");
  a_dma_copy: assert property (dma_capture && !avs_write |=>
    {prev_status_copy, prev_byte_count} == $past({dma_desc_word1[31:16], dma_desc_word1[11:0]}))
    else $error("capture copy wrong");
  a_read_reserved: assert property (avs_read && !avs_waitrequest |->
    avs_readdata[31:16] == 16'h0000) else $error("upper read bits not zero");
  a_style_narrow: assert property (structure_style_code == TXS_STYLE_NARROW |->
    !wide_structure_flag && init_burst_ok && !ring_burst_ok) else $error("style 00 decode");
  a_style_wide_nb: assert property (structure_style_code == TXS_STYLE_WIDE_NB |->
    wide_structure_flag && init_burst_ok && !ring_burst_ok) else $error("style 02 decode");
  a_style_wide_burst: assert property (structure_style_code == TXS_STYLE_WIDE_BRST |->
    wide_structure_flag && init_burst_ok && ring_burst_ok) else $error("style 03 decode");
  a_style_reset: assert property ($rose(rst_n) |->
    structure_style_code == TXS_STYLE_RESET && stop_bit) else $error("style not 00 after reset");
endmodule : txs_shadow_properties

bind txs_shadow_regs txs_shadow_properties u_txs_shadow_properties (.ref_clk, .rst_n,
  .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
  .dma_capture, .dma_desc_word1, .prev_desc_ptr_low, .prev_byte_count, .prev_status_copy,
  .structure_style_code, .wide_structure_flag, .init_burst_ok, .ring_burst_ok, .stop_bit,
  .suspend_bit);

// ---- tb/txs_shadow_regs_test.sv ----
// testbench: access, style decode, gating, capture and reset of the tx shadow bank
`timescale 1ns/10ps
module txs_shadow_regs_test;
  import txs_pkg::*;
  logic        ref_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        rd_q = 1'b0, wr_q = 1'b0, cap = 1'b0, nxv = 1'b0, wide, ib, rb, sv, stp, spn;
  logic [7:0]  adr = 8'h00, code;
  logic [31:0] wd = 32'h0, rdd, rd, r, a = 32'h0, w = 32'h0;
  logic [31:0] m [5];
  logic [15:0] nbi = 16'h0, lo, hi, st, nb;
  logic [11:0] bc;
  logic        wt;
  int          error_cnt = 0;
  int          checks = 0;
  logic [7:0]  codes [5] = '{8'h00, 8'h02, 8'h03, 8'h01, 8'h04};
  logic [3:0]  e;

  always #2.5 ref_clk = ~ref_clk;

  txs_shadow_regs u_txs_shadow_regs (.ref_clk, .rst_n, .avs_address(adr), .avs_read(rd_q),
    .avs_write(wr_q), .avs_writedata(wd), .avs_byteenable(4'h3), .avs_readdata(rdd),
    .avs_waitrequest(wt), .dma_capture(cap), .dma_desc_addr(a), .dma_desc_word1(w),
    .dma_next_valid(nxv), .dma_next_buf_low(nbi), .prev_desc_ptr_low(lo),
    .prev_desc_ptr_high(hi), .prev_byte_count(bc), .prev_status_copy(st),
    .next_buffer_ptr_low(nb), .structure_style_code(code), .wide_structure_flag(wide),
    .init_burst_ok(ib), .ring_burst_ok(rb), .style_valid(sv), .stop_bit(stp),
    .suspend_bit(spn));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // request held until waitrequest is seen low at a rising edge; one idle edge after
  task automatic bus(input logic wr, input logic [7:0] ad, input logic [31:0] d);
    adr <= ad;
    wd <= d;
    wr_q <= wr;
    rd_q <= !wr;
    @(posedge ref_clk);
    while (wt !== 1'b0) @(posedge ref_clk);
    rd = rdd;
    wr_q <= 1'b0;
    rd_q <= 1'b0;
    @(posedge ref_clk);
  endtask : bus
  task automatic rdchk(input logic [7:0] ad, input logic [31:0] exp);
    bus(1'b0, ad, 32'h0);
    chk(rd, exp);
  endtask : rdchk
  // byte count keeps twelve bits only
  function automatic logic [31:0] exp_rd(input int i, input logic [31:0] v);
    return (i == 2) ? (v & 32'h0000_0FFF) : (v & 32'h0000_FFFF);
  endfunction : exp_rd
  // decode as {valid, wide, init burst, ring burst}; reserved codes allow no bursts
  function automatic logic [3:0] exp_style(input logic [7:0] c);
    if (c == TXS_STYLE_NARROW) return 4'b1010;
    else if (c == TXS_STYLE_WIDE_NB) return 4'b1110;
    else if (c == TXS_STYLE_WIDE_BRST) return 4'b1111;
    else if (c == TXS_STYLE_RSVD1) return 4'b0100;
    return 4'b0000;
  endfunction : exp_style
  task automatic give_verdict();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : give_verdict

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    r = $urandom(32);
    codes[4] = 8'($urandom_range(255, 4));
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    rdchk(TXS_ADDR_CTRL, 32'h0000_0001);
    rdchk(TXS_ADDR_STYLE, 32'h0000_0000);
    rdchk(8'h1C, 32'h0000_0000);
    $display("done: defaults");
    repeat (4) for (int i = 0; i < 5; i++) begin
      m[i] = $urandom & 32'h0000_FFFF;
      bus(1'b1, 8'(4 * i), m[i]);
      rdchk(8'(4 * i), exp_rd(i, m[i]));
    end
    $display("done: shadow access");
    foreach (codes[k]) begin
      e = exp_style(codes[k]);
      bus(1'b1, TXS_ADDR_STYLE, {24'h1, codes[k]});
      rdchk(TXS_ADDR_STYLE, {23'h0, e[2], codes[k]});
      chk({28'h0, sv, wide, ib, rb}, {28'h0, e});
      chk({24'h0, code}, {24'h0, codes[k]});
    end
    $display("done: style");
    bus(1'b1, TXS_ADDR_CTRL, 32'h0000_0000);
    chk({30'h0, stp, spn}, 32'h0000_0000);
    bus(1'b1, TXS_ADDR_PREV_DESC_LOW, ~m[0] & 32'h0000_FFFF);
    bus(1'b1, TXS_ADDR_STYLE, 32'h0000_0002);
    rdchk(TXS_ADDR_PREV_DESC_HIGH, 32'h0000_0000);
    bus(1'b1, TXS_ADDR_CTRL, 32'h0000_0002);
    chk({30'h0, stp, spn}, 32'h0000_0001);
    rdchk(TXS_ADDR_PREV_DESC_LOW, m[0]);
    rdchk(TXS_ADDR_STYLE, {23'h0, e[2], codes[4]});
    $display("done: gating");
    repeat (6) begin
      a <= $urandom;
      w <= $urandom;
      nbi <= 16'($urandom);
      cap <= 1'b1;
      nxv <= 1'b1;
      @(posedge ref_clk);
      cap <= 1'b0;
      nxv <= 1'b0;
      @(posedge ref_clk);
      chk({hi, lo}, a);
      chk({st, 4'h0, bc}, {w[31:16], 4'h0, w[11:0]});
      chk({16'h0, nb}, {16'h0, nbi});
      rdchk(TXS_ADDR_PREV_BCOUNT, {20'h0, w[11:0]});
    end
    $display("done: capture");
    rst_n <= 1'b0;
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    chk({hi, lo}, a);
    chk({30'h0, stp, spn}, 32'h0000_0002);
    chk({st, bc, nb}, {w[31:16], w[11:0], nbi});
    rdchk(TXS_ADDR_STYLE, 32'h0000_0000);
    $display("done: reset keeps shadow");
    give_verdict();
  end

  // hang guard well above the few hundred cycles the tests need
  initial begin
    repeat (5000) @(posedge ref_clk);
    error_cnt++;
    $display("Error %0t: timeout", $time);
    give_verdict();
  end
endmodule : txs_shadow_regs_test
